// ### design/scs_pkg.sv
package scs_pkg;
    // Result width and number of bit trials
    localparam int RES_W = 16;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] MIDSCALE_SB = 16'h8000;
    localparam logic [15:0] SAT_HI_SB = 16'hFFFF;
    localparam logic [15:0] SAT_LO_SB = 16'h0000;
    localparam logic [15:0] MSB_WEIGHT = 16'h8000;

    // Clock and timing
    localparam int CLK_MHZ = 200;
    localparam int CONV_PERIOD_NS = 10000;
    localparam int CONV_PERIOD_CYC = CONV_PERIOD_NS * CLK_MHZ / 1000;
    localparam int TRIAL_NS = 200;
    localparam int TRIAL_CYC = (TRIAL_NS * CLK_MHZ + 999) / 1000;
    localparam int ACQ_NS = 1500;
    localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;
    localparam logic [4:0] TRIAL_LAST = 5'h0F;

    // FIFO depth and register offsets
    localparam int FIFO_DEPTH = 16;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] DATA_OFS = 12'h008;
    localparam logic [11:0] COUNT_OFS = 12'h00C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_CODING_BIT = 0;
    localparam int CTRL_SLEEP_BIT = 1;
    localparam int CTRL_RESET_BIT = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACQ = 3'b001,
        ST_WAIT = 3'b010,
        ST_TRIAL = 3'b011,
        ST_ASSEMBLE = 3'b100
    } scs_state_t;

    // Comparator feedback and analog range flags
    typedef struct packed {
        logic keep;
        logic over_range;
        logic under_range;
    } scs_cmp_t;

    // Conversion sample stored in the FIFO
    typedef struct packed {
        logic coding;
        logic [15:0] code;
    } scs_sample_t;

    // Straight binary to output coding
    function automatic logic [15:0] scs_format(input logic [15:0] sb, input logic twos);
        scs_format = twos ? {~sb[15], sb[14:0]} : sb;
    endfunction
endpackage

// ### design/scs_sync.sv
module scs_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic din,
    output logic dout
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // Three stages; change accepted when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// ### design/scs_fifo.sv
module scs_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic push;
    logic pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage written at the write index
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count <= '0;
        end else if (flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ### design/scs_top.sv
module scs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conversion_start_n,
    input wire logic coding_select,
    input wire logic sleep_request,
    input wire logic converter_reset,
    input wire scs_pkg::scs_cmp_t cmp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic busy,
    output logic [15:0] trial_word,
    output logic sample_hold,
    output logic array_power,
    output logic [15:0] result,
    output logic result_valid
);
    import scs_pkg::*;

    // Sequencer state
    scs_state_t state_reg;

    // Synchronised pins and previous start level
    logic start_n_sync;
    logic coding_sync;
    logic sleep_sync;
    logic reset_sync;
    logic start_n_prev_reg;

    // Conversion counters and trial word
    logic [CNT_W-1:0] cnt_reg;
    logic [4:0] trial_reg;
    logic [15:0] weight_reg;
    logic [15:0] sar_reg;
    logic over_reg;
    logic under_reg;

    // Control register and effective controls
    logic [31:0] ctrl_reg;
    logic coding_eff;
    logic sleep_eff;
    logic reset_eff;
    logic start_fall;
    logic [15:0] code_next;
    logic in_trial;
    logic assemble_now;

    // Result buffer and bus side
    scs_sample_t fifo_in;
    scs_sample_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic fifo_push;
    logic [4:0] fifo_count;
    logic apb_access;
    logic [15:0] rate_cnt_reg;

    // Keep the trial bit or drop it, as the comparator decided
    function automatic logic [15:0] trial_keep(input logic [15:0] word,
        input logic [15:0] weight, input logic keep);
        trial_keep = keep ? word : (word & ~weight);
    endfunction

    // Pin inputs through three-stage synchronisers
    scs_sync u_sync_start (.pclk(pclk), .presetn(presetn), .din(conversion_start_n),
        .dout(start_n_sync));
    scs_sync u_sync_coding (.pclk(pclk), .presetn(presetn), .din(coding_select),
        .dout(coding_sync));
    scs_sync u_sync_sleep (.pclk(pclk), .presetn(presetn), .din(sleep_request),
        .dout(sleep_sync));
    scs_sync u_sync_reset (.pclk(pclk), .presetn(presetn), .din(converter_reset),
        .dout(reset_sync));

    // Pin or control bit may request each function
    assign coding_eff = coding_sync | ctrl_reg[CTRL_CODING_BIT];
    assign sleep_eff = sleep_sync | ctrl_reg[CTRL_SLEEP_BIT];
    assign reset_eff = reset_sync | ctrl_reg[CTRL_RESET_BIT];
    assign start_fall = start_n_prev_reg && !start_n_sync;
    assign apb_access = psel && penable;

    // Phase decodes shared by pins and result buffer
    assign in_trial = (state_reg == ST_TRIAL) && !reset_eff;
    assign assemble_now = (state_reg == ST_ASSEMBLE) && !reset_eff;

    // Final code from trial bits with saturation and coding
    always_comb begin
        if (over_reg) begin
            code_next = scs_format(SAT_HI_SB, !coding_eff);
        end else if (under_reg) begin
            code_next = scs_format(SAT_LO_SB, !coding_eff);
        end else begin
            code_next = scs_format(sar_reg, !coding_eff);
        end
    end

    // Previous start level for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_n_prev_reg <= 1'b1;
        end else begin
            start_n_prev_reg <= start_n_sync;
        end
    end

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_ACQ;
            cnt_reg <= '0;
            trial_reg <= '0;
            weight_reg <= MSB_WEIGHT;
            sar_reg <= RESULT_RST;
            over_reg <= 1'b0;
            under_reg <= 1'b0;
        end else if (reset_eff) begin
            state_reg <= ST_ACQ;
            cnt_reg <= '0;
            trial_reg <= '0;
            weight_reg <= MSB_WEIGHT;
            sar_reg <= RESULT_RST;
            over_reg <= 1'b0;
            under_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // Array stays off until sleep is released
                    if (!sleep_eff) begin
                        state_reg <= ST_ACQ;
                        cnt_reg <= '0;
                    end
                end
                ST_ACQ: begin
                    if (sleep_eff) begin
                        state_reg <= ST_IDLE;
                    end else if (cnt_reg == CNT_W'(ACQ_CYC - 1)) begin
                        // Start already low converts now, else wait for its edge
                        state_reg <= start_n_sync ? ST_WAIT : ST_TRIAL;
                        cnt_reg <= '0;
                        trial_reg <= '0;
                        weight_reg <= MSB_WEIGHT;
                        sar_reg <= MSB_WEIGHT;
                        over_reg <= 1'b0;
                        under_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Sleep or a fresh falling edge of start leaves here
                    if (sleep_eff) begin
                        state_reg <= ST_IDLE;
                    end else if (start_fall) begin
                        state_reg <= ST_TRIAL;
                    end
                end
                ST_TRIAL: begin
                    if (cnt_reg == CNT_W'(TRIAL_CYC - 1)) begin
                        cnt_reg <= '0;
                        // Range flags stay set for the rest of this conversion
                        if (cmp.over_range) begin
                            over_reg <= 1'b1;
                        end
                        if (cmp.under_range) begin
                            under_reg <= 1'b1;
                        end
                        // Keep or drop trial bit, try next half weight
                        if (trial_reg == TRIAL_LAST) begin
                            sar_reg <= trial_keep(sar_reg, weight_reg, cmp.keep);
                            state_reg <= ST_ASSEMBLE;
                        end else begin
                            sar_reg <= trial_keep(sar_reg, weight_reg, cmp.keep)
                                | (weight_reg >> 1);
                            weight_reg <= weight_reg >> 1;
                            trial_reg <= trial_reg + 1'b1;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_ASSEMBLE: begin
                    state_reg <= ST_ACQ;
                    cnt_reg <= '0;
                end
                default: begin
                    state_reg <= ST_ACQ;
                end
            endcase
        end
    end

    // Phase pins from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            trial_word <= '0;
            sample_hold <= 1'b0;
            array_power <= 1'b0;
        end else begin
            trial_word <= sar_reg;
            busy <= in_trial;
            sample_hold <= in_trial;
            array_power <= in_trial;
        end
    end

    // Final code latched with a one-cycle valid pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= RESULT_RST;
            result_valid <= 1'b0;
        end else begin
            result_valid <= assemble_now;
            if (assemble_now) begin
                result <= code_next;
            end
        end
    end

    // Results queued for software
    assign fifo_in.coding = coding_eff;
    assign fifo_in.code = code_next;
    assign fifo_push = assemble_now; // Full buffer drops it, no stall

    // Pop on the first access cycle only, so one read takes one word
    assign fifo_pop = apb_access && !pwrite && (paddr == DATA_OFS) && !pready;

    scs_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(reset_eff),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .count(fifo_count)
    );

    // Conversions counted for rate monitoring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt_reg <= '0;
        end else if (fifo_push) begin
            rate_cnt_reg <= rate_cnt_reg + 1'b1;
        end
    end

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
        end else if (apb_access && pwrite && !pready && paddr == CTRL_OFS) begin
            ctrl_reg <= {29'h0000_000, pwdata[2:0]};
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (apb_access && !pready) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            // Unmapped offsets answer with an error and zero data
            case (paddr)
                CTRL_OFS: prdata <= ctrl_reg;
                STATUS_OFS: prdata <= {20'h0_0000, fifo_count, fifo_in_ready,
                    fifo_out_valid, busy, state_reg, 1'b0};
                DATA_OFS: prdata <= {14'h0000, fifo_out_valid, fifo_out};
                COUNT_OFS: prdata <= {16'h0000, rate_cnt_reg};
                default: pslverr <= 1'b1;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

// ### tb/scs_analog_model.sv
module scs_analog_model (
    input wire logic [15:0] trial_word,
    input wire logic [15:0] target,
    input wire logic over_in,
    input wire logic under_in,
    output scs_pkg::scs_cmp_t cmp
);
    import scs_pkg::*;
    // Comparator keeps a trial bit while the word stays at or below the held sample
    assign cmp.keep = (trial_word <= target);
    // Range flags held for the whole conversion
    assign cmp.over_range = over_in;
    assign cmp.under_range = under_in;
endmodule

// ### tb/scs_checker_assertions.sv
module scs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic coding_select,
    input wire logic sleep_request,
    input wire logic converter_reset,
    input wire scs_pkg::scs_cmp_t cmp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic busy,
    input wire logic [15:0] trial_word,
    input wire logic [15:0] result,
    input wire logic result_valid
);
    import scs_pkg::*;
    logic [11:0] bcnt;
    logic [11:0] icnt;
    logic ovr;
    logic und;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Busy run length and idle run length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt <= 12'h000;
            icnt <= 12'h000;
        end else begin
            bcnt <= busy ? bcnt + 12'h001 : 12'h000;
            icnt <= busy ? 12'h000 : ((icnt == 12'hFFF) ? icnt : icnt + 12'h001);
        end
    end
    // Range flags seen while busy, kept until busy has fallen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr <= 1'b0;
            und <= 1'b0;
        end else begin
            ovr <= busy & (ovr | cmp.over_range);
            und <= busy & (und | cmp.under_range);
        end
    end
    AST_DONE_PULSE: assert property (
        $fell(busy) && !converter_reset |-> result_valid) else $error("busy fell without result");
    AST_VALID_AT_FALL: assert property (
        result_valid |-> !busy && $past(busy)) else $error("result pulse away from busy fall");
    AST_CONV_LEN: assert property (
        $fell(busy) && result_valid |-> bcnt >= 16 * TRIAL_CYC && bcnt <= 16 * TRIAL_CYC + 4)
        else $error("conversion length wrong");
    AST_FIRST_TRIAL: assert property (
        $rose(busy) |-> ##[0:3] trial_word == 16'h8000) else $error("first trial not MSB");
    AST_ACQ_MIN: assert property (
        $rose(busy) |-> icnt >= ACQ_CYC) else $error("acquisition too short");
    AST_SAT_HI: assert property (
        result_valid && ovr && coding_select |-> result == 16'hFFFF) else $error("no high clamp");
    AST_SAT_LO: assert property (
        result_valid && und && !ovr && coding_select |-> result == 16'h0000)
        else $error("no low clamp");
    AST_SLEEP_BLOCK: assert property (
        sleep_request && $past(sleep_request, 8) |-> !$rose(busy)) else $error("start in sleep");
    AST_ABORT: assert property (
        converter_reset && $past(converter_reset, 6) |-> !busy) else $error("abort ignored");
    AST_APB_ANSWER: assert property (
        psel && penable && !pready |=> pready) else $error("apb answer late");
    // Main scenarios
    COV_DONE: cover property ($fell(busy) && result_valid);
    COV_OVER: cover property (result_valid && ovr);
    COV_ABORT: cover property (converter_reset && busy);
endmodule
bind scs_top scs_checker u_checker (
    .pclk(pclk), .presetn(presetn), .coding_select(coding_select),
    .sleep_request(sleep_request), .converter_reset(converter_reset), .cmp(cmp),
    .psel(psel), .penable(penable), .pready(pready), .busy(busy),
    .trial_word(trial_word), .result(result), .result_valid(result_valid)
);

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    logic pclk, presetn, conversion_start_n, coding_select, sleep_request, converter_reset;
    logic psel, penable, pwrite, pready, pslverr, busy, sample_hold, array_power;
    logic result_valid, ovr, und, er, seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] trial_word, result, tgt;
    scs_cmp_t cmp;
    int failures, checks_done, lat, i, k;
    logic [34:0] tbl [9];
    scs_top uut (.pclk(pclk), .presetn(presetn), .conversion_start_n(conversion_start_n),
        .coding_select(coding_select), .sleep_request(sleep_request),
        .converter_reset(converter_reset), .cmp(cmp), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy), .trial_word(trial_word), .sample_hold(sample_hold),
        .array_power(array_power), .result(result), .result_valid(result_valid));
    scs_analog_model am (.trial_word(trial_word), .target(tgt), .over_in(ovr),
        .under_in(und), .cmp(cmp));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures %0d checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // One conversion: {target, over, under, coding, expected code}
    task automatic conv(input logic [34:0] e, input logic sl);
        {tgt, ovr, und, coding_select} <= e[34:16];
        conversion_start_n <= 1'b0;
        i = 0;
        while (busy !== 1'b1 && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        lat = i;
        chk({sample_hold, array_power}, 2'b11);
        conversion_start_n <= 1'b1;
        sleep_request <= sl;
        while (result_valid !== 1'b1 && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        chk(result, e[15:0]);
        chk(i <= CONV_PERIOD_CYC, 1);
        repeat (2) @(posedge pclk);
        chk(array_power, 0);
    endtask
    // Watchdog
    initial begin
        #400us;
        failures++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, tgt, ovr, und} = '0;
        {presetn, sleep_request, converter_reset} = '0;
        {conversion_start_n, coding_select} = 2'b11;
        failures = 0;
        checks_done = 0;
        tbl = '{{16'h1234, 3'b001, 16'h1234}, {16'h8000, 3'b000, 16'h0000},
            {16'h7FFF, 3'b000, 16'hFFFF}, {16'h0001, 3'b001, 16'h0001},
            {16'hFFFF, 3'b001, 16'hFFFF}, {16'h0000, 3'b101, 16'hFFFF},
            {16'h0000, 3'b100, 16'h7FFF}, {16'hFFFF, 3'b011, 16'h0000},
            {16'hFFFF, 3'b010, 16'h8000}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        conv(tbl[0], 1'b0);
        chk(lat >= ACQ_CYC, 1);
        // Fill the buffer past full while nobody reads
        for (k = 1; k < 17; k++) conv(tbl[k % 9], 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        chk(rd[11:6], 6'h20);
        apb(1'b0, COUNT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0011);
        for (k = 0; k < 16; k++) begin
            apb(1'b0, DATA_OFS, 32'h0000_0000);
            chk(rd[17:0], {1'b1, tbl[k % 9][16:0]});
        end
        apb(1'b0, DATA_OFS, 32'h0000_0000);
        chk(rd[17], 0);
        apb(1'b0, STATUS_OFS, 32'h0000_0000);
        chk(rd[11:5], 7'h02);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(er, 1);
        // Control register keeps three bits; reset bit holds the sequencer
        apb(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0007);
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        // Start held high past acquisition, then a falling edge
        repeat (400) @(posedge pclk);
        chk(busy, 0);
        conv(tbl[1], 1'b0);
        chk(lat < 10, 1);
        // Sleep raised mid conversion: it finishes, no further start
        conv(tbl[5], 1'b1);
        conversion_start_n <= 1'b0;
        seen = 1'b0;
        repeat (1500) begin
            @(posedge pclk);
            seen = seen | (busy === 1'b1);
        end
        chk(seen, 0);
        sleep_request <= 1'b0;
        conv(tbl[3], 1'b0);
        // Abort a running conversion
        conversion_start_n <= 1'b0;
        i = 0;
        while (busy !== 1'b1 && i < 3000) begin
            @(posedge pclk);
            i++;
        end
        repeat (100) @(posedge pclk);
        chk(busy, 1);
        converter_reset <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(busy, 0);
        converter_reset <= 1'b0;
        conversion_start_n <= 1'b1;
        @(posedge pclk);
        conv(tbl[2], 1'b0);
        // Coding forced to straight binary by the control bit
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        conv({tbl[1][34:16], 16'h8000}, 1'b0);
        finish_test();
    end
endmodule
